/* dsd_pkg.sv */
// Constants, opcode patterns and carrier types for the instruction decoder.
//
// Functional notes
// - Immediate instructions finish in one cycle.
// - Top bits 100: multiply by 13-bit constant.
// - Short accumulator load zero-extends eight bits.
// - Pointer-load immediate takes bit 0, one cycle.
// - Page-load immediate takes bit 0, one cycle.
// - Post-decrement lowers selected aux register by one.
// - New pointer value loads after execution.
// - Add with shift: one cycle, one word.
// - Upper store shifts by three-bit field.
// - Branches and calls: two words, two cycles.
// - Load temp and accumulate: one cycle.
// - Branch on test pin acts as two-cycle nop.
// - Stack push and pop take two cycles.
// - Ports two cycles; table moves three cycles.
// - Clear low, load upper half, one cycle.
// - Unsigned add without sign extension, one cycle.
// - Temp load, accumulate, copy word forward.
// - Multiply temp by memory into product.
// - Status word load and store, one cycle.
// - Aux immediate and memory loads, bit 8 selects; the memory load sets mem_rd, leaves ar0 and ar1 unchanged and ignores bit 8.
// - Data copy to next location, one cycle.
// - Absolute value and accumulator clear, one cycle.
// - Bit 5 increments, bit 4 decrements aux.
// - Direct address joins page bit to seven bits.
package dsd_pkg;
  localparam int DSD_W = 16;
  localparam int DSD_ACC_W = 32;
  localparam int DSD_AR_W = 16;
  localparam logic [7:0] DSD_HB_ADDU = 8'h61;
  localparam logic [7:0] DSD_HB_ZLDH = 8'h65;
  localparam logic [7:0] DSD_HB_MAR = 8'h68;
  localparam logic [7:0] DSD_HB_COPY = 8'h69;
  localparam logic [7:0] DSD_HB_LT = 8'h6a;
  localparam logic [7:0] DSD_HB_LTD = 8'h6b;
  localparam logic [7:0] DSD_HB_LTAC = 8'h6c;
  localparam logic [7:0] DSD_HB_MULM = 8'h6d;
  localparam logic [7:0] DSD_HB_PGIM = 8'h6e;
  localparam logic [7:0] DSD_HB_LTBR = 8'h67;
  localparam logic [7:0] DSD_HB_STLD = 8'h7b;
  localparam logic [7:0] DSD_HB_STST = 8'h7c;
  localparam logic [7:0] DSD_HB_TBW = 8'h7d;
  localparam logic [7:0] DSD_HB_ACIM = 8'h7e;
  localparam logic [7:0] DSD_HB_MISC = 8'h7f;
  localparam logic [7:0] DSD_LB_MAG = 8'h88;
  localparam logic [7:0] DSD_LB_CLR = 8'h89;
  localparam logic [7:0] DSD_LB_PUSH = 8'h9c;
  localparam logic [7:0] DSD_LB_POP = 8'h9d;
  localparam logic [7:0] DSD_LB_APAC = 8'h8f;
  localparam logic [7:0] DSD_LB_PAC = 8'h8e;
  localparam logic [7:0] DSD_LB_SPAC = 8'h90;
  localparam logic [3:0] DSD_BR_TESTPIN = 4'h6;
  localparam logic [1:0] DSD_CYC_ONE = 2'h1;
  localparam logic [1:0] DSD_CYC_TWO = 2'h2;
  localparam logic [1:0] DSD_CYC_THREE = 2'h3;
  localparam logic [1:0] DSD_RST_PTR = 2'h0;

  typedef enum logic [2:0] {
    DSD_S_EXEC = 3'h1,
    DSD_S_WORD2 = 3'h2,
    DSD_S_WAIT = 3'h4
  } dsd_state_t;

  // Accumulator operation selector.
  typedef enum logic [3:0] {
    DSD_A_NONE = 4'h0, DSD_A_ADD_SH = 4'h1, DSD_A_ADD_US = 4'h2, DSD_A_LOAD_K = 4'h3,
    DSD_A_ZLDH = 4'h4, DSD_A_ADD_P = 4'h5, DSD_A_MAG = 4'h6, DSD_A_ZERO = 4'h7,
    DSD_A_LOAD_P = 4'h8, DSD_A_SUB_P = 4'h9, DSD_A_POP = 4'ha
  } dsd_acc_op_t;

  // Decoded control word issued for each executed instruction.
  typedef struct packed {
    logic valid;
    dsd_acc_op_t acc_op;
    logic [3:0] shift;
    logic [12:0] mult_k;
    logic mult_k_en;
    logic mult_mem_en;
    logic load_t;
    logic mem_rd;
    logic mem_wr_acc_hi;
    logic [2:0] store_shift;
    logic copy_next;
    logic status_ld;
    logic status_st;
    logic [7:0] dma;
    logic [7:0] imm8;
    logic port_in;
    logic port_out;
    logic [2:0] port_addr;
    logic table_rd;
    logic table_wr;
    logic push;
    logic pop;
  } dsd_ctrl_t;

  typedef struct packed {
    dsd_state_t state;
    logic [1:0] wait_cnt;
    logic [3:0] br_code;
    logic asel;
    logic pg;
    logic [DSD_AR_W-1:0] ar0;
    logic [DSD_AR_W-1:0] ar1;
    dsd_ctrl_t ctrl;
    logic branch;
    logic [3:0] branch_code;
    logic [11:0] branch_addr;
    logic fetch_word2;
    logic busy;
  } dsd_regs_t;
endpackage

/* dsd_decoder.sv */
// Instruction decoder: decodes fetched words into control and keeps pointers.
//
`timescale 1ns/10ps
module dsd_decoder
  import dsd_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic word_valid_in,
  input wire logic [WORD_W-1:0] word_in,
  output logic word_ready_out,
  output dsd_ctrl_t ctrl_out,
  output logic asel_out,
  output logic pg_out,
  output logic [DSD_AR_W-1:0] ar0_out,
  output logic [DSD_AR_W-1:0] ar1_out,
  output logic fetch_word2_out,
  output logic branch_out,
  output logic [3:0] branch_code_out,
  output logic [11:0] branch_addr_out
);

  initial begin
    if (WORD_W != DSD_W) begin
      $error("dsd_decoder supports only 16-bit instruction words");
    end
  end

  dsd_regs_t r_ff;
  dsd_regs_t nxt_r;

  logic take;
  logic [7:0] hb;
  logic [7:0] lb;
  logic ind;
  logic [7:0] sel_ar;

  assign take = word_valid_in && (r_ff.state != DSD_S_WAIT);
  assign hb = word_in[15:8];
  assign lb = word_in[7:0];
  assign ind = word_in[7];
  assign sel_ar = r_ff.asel ? r_ff.ar1[7:0] : r_ff.ar0[7:0];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic upd_ar;
    logic [DSD_AR_W-1:0] cur;
    upd_ar = 1'b0;
    cur = '0;
    nxt_r = r_ff;
    nxt_r.ctrl = '0;
    nxt_r.branch = 1'b0;
    nxt_r.fetch_word2 = 1'b0;
    case (r_ff.state)
      DSD_S_EXEC: begin
        if (take) begin
          nxt_r.ctrl.valid = 1'b1;
          // Direct address joins page bit and seven address bits.
          nxt_r.ctrl.dma = ind ? sel_ar : {r_ff.pg, word_in[6:0]};
          nxt_r.ctrl.imm8 = lb;
          upd_ar = ind;
          if (word_in[15:13] == 3'b100) begin
            upd_ar = 1'b0;
            nxt_r.ctrl.mult_k = word_in[12:0];
            nxt_r.ctrl.mult_k_en = 1'b1;
          end else if (word_in[15:12] == 4'h0) begin
            nxt_r.ctrl.acc_op = DSD_A_ADD_SH;
            nxt_r.ctrl.shift = word_in[11:8];
            nxt_r.ctrl.mem_rd = 1'b1;
          end else if (word_in[15:11] == 5'b01011) begin
            nxt_r.ctrl.mem_wr_acc_hi = 1'b1;
            nxt_r.ctrl.store_shift = word_in[10:8];
          end else if (word_in[15:12] == 4'hf) begin
            upd_ar = 1'b0;
            nxt_r.br_code = word_in[11:8];
            nxt_r.fetch_word2 = 1'b1;
            nxt_r.ctrl.valid = 1'b0;
            nxt_r.state = DSD_S_WORD2;
          end else if (word_in[15:12] == 4'h4) begin
            nxt_r.ctrl.port_in = !word_in[11];
            nxt_r.ctrl.port_out = word_in[11];
            nxt_r.ctrl.port_addr = word_in[10:8];
            nxt_r.wait_cnt = DSD_CYC_TWO - 2'h1;
            nxt_r.state = DSD_S_WAIT;
          end else if (word_in[15:9] == 7'b0111000) begin
            upd_ar = 1'b0;
            if (word_in[8]) begin
              nxt_r.ar1 = {8'h00, lb};
            end else begin
              nxt_r.ar0 = {8'h00, lb};
            end
          end else if (word_in[15:9] == 7'b0011100) begin
            nxt_r.ctrl.mem_rd = 1'b1;
          end else begin
            case (hb)
              DSD_HB_ADDU: begin
                nxt_r.ctrl.acc_op = DSD_A_ADD_US;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_ZLDH: begin
                nxt_r.ctrl.acc_op = DSD_A_ZLDH;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_MAR: begin
                if (!ind) begin
                  upd_ar = 1'b0;
                end
                if (lb[7:1] == 7'b1000000) begin
                  upd_ar = 1'b0;
                  nxt_r.asel = lb[0];
                end
              end
              DSD_HB_COPY: begin
                nxt_r.ctrl.mem_rd = 1'b1;
                nxt_r.ctrl.copy_next = 1'b1;
              end
              DSD_HB_LT: begin
                nxt_r.ctrl.load_t = 1'b1;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_LTD: begin
                nxt_r.ctrl.load_t = 1'b1;
                nxt_r.ctrl.acc_op = DSD_A_ADD_P;
                nxt_r.ctrl.mem_rd = 1'b1;
                nxt_r.ctrl.copy_next = 1'b1;
              end
              DSD_HB_LTAC: begin
                nxt_r.ctrl.load_t = 1'b1;
                nxt_r.ctrl.acc_op = DSD_A_ADD_P;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_MULM: begin
                nxt_r.ctrl.mult_mem_en = 1'b1;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_PGIM: begin
                upd_ar = 1'b0;
                nxt_r.pg = word_in[0];
              end
              DSD_HB_STLD: begin
                upd_ar = ind;
                nxt_r.ctrl.status_ld = 1'b1;
                nxt_r.ctrl.mem_rd = 1'b1;
              end
              DSD_HB_STST: begin
                nxt_r.ctrl.status_st = 1'b1;
              end
              DSD_HB_LTBR: begin
                nxt_r.ctrl.table_rd = 1'b1;
                nxt_r.wait_cnt = DSD_CYC_THREE - 2'h1;
                nxt_r.state = DSD_S_WAIT;
              end
              DSD_HB_TBW: begin
                nxt_r.ctrl.table_wr = 1'b1;
                nxt_r.wait_cnt = DSD_CYC_THREE - 2'h1;
                nxt_r.state = DSD_S_WAIT;
              end
              DSD_HB_ACIM: begin
                upd_ar = 1'b0;
                nxt_r.ctrl.acc_op = DSD_A_LOAD_K;
              end
              DSD_HB_MISC: begin
                upd_ar = 1'b0;
                case (lb)
                  DSD_LB_MAG: nxt_r.ctrl.acc_op = DSD_A_MAG;
                  DSD_LB_CLR: nxt_r.ctrl.acc_op = DSD_A_ZERO;
                  DSD_LB_APAC: nxt_r.ctrl.acc_op = DSD_A_ADD_P;
                  DSD_LB_PAC: nxt_r.ctrl.acc_op = DSD_A_LOAD_P;
                  DSD_LB_SPAC: nxt_r.ctrl.acc_op = DSD_A_SUB_P;
                  DSD_LB_PUSH: begin
                    nxt_r.ctrl.push = 1'b1;
                    nxt_r.wait_cnt = DSD_CYC_TWO - 2'h1;
                    nxt_r.state = DSD_S_WAIT;
                  end
                  DSD_LB_POP: begin
                    nxt_r.ctrl.pop = 1'b1;
                    nxt_r.ctrl.acc_op = DSD_A_POP;
                    nxt_r.wait_cnt = DSD_CYC_TWO - 2'h1;
                    nxt_r.state = DSD_S_WAIT;
                  end
                  default: nxt_r.ctrl.acc_op = DSD_A_NONE;
                endcase
              end
              default: begin
                nxt_r.ctrl.mem_rd = 1'b0;
              end
            endcase
          end
          // Indirect post-modify happens after the access.
          if (upd_ar) begin
            cur = r_ff.asel ? r_ff.ar1 : r_ff.ar0;
            if (word_in[5]) begin
              cur = cur + 16'h0001;
            end else if (word_in[4]) begin
              cur = cur - 16'h0001;
            end
            if (word_in[15:9] == 7'b0011100) begin
              cur = r_ff.asel ? r_ff.ar1 : r_ff.ar0;
            end
            if (r_ff.asel) begin
              nxt_r.ar1 = cur;
            end else begin
              nxt_r.ar0 = cur;
            end
            if (!word_in[3]) begin
              nxt_r.asel = word_in[0];
            end
          end
        end
      end
      DSD_S_WORD2: begin
        nxt_r.fetch_word2 = 1'b1;
        if (word_valid_in) begin
          nxt_r.fetch_word2 = 1'b0;
          nxt_r.state = DSD_S_EXEC;
          // The test pin is absent, so that branch is never taken.
          nxt_r.branch = (r_ff.br_code != DSD_BR_TESTPIN);
          nxt_r.branch_code = r_ff.br_code;
          nxt_r.branch_addr = word_in[11:0];
          nxt_r.ctrl.valid = 1'b1;
        end
      end
      DSD_S_WAIT: begin
        if (r_ff.wait_cnt <= 2'h1) begin
          nxt_r.state = DSD_S_EXEC;
        end
        nxt_r.wait_cnt = r_ff.wait_cnt - 2'h1;
      end
      default: begin
        nxt_r.state = DSD_S_EXEC;
      end
    endcase
    nxt_r.busy = (nxt_r.state == DSD_S_WAIT);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r_ff <= '{state: DSD_S_EXEC, default: '0};
    end else if (clk_en_in) begin
      r_ff <= nxt_r;
    end
  end

  assign word_ready_out = 1'b1 ^ r_ff.busy;
  assign ctrl_out = r_ff.ctrl;
  assign asel_out = r_ff.asel;
  assign pg_out = r_ff.pg;
  assign ar0_out = r_ff.ar0;
  assign ar1_out = r_ff.ar1;
  assign fetch_word2_out = r_ff.fetch_word2;
  assign branch_out = r_ff.branch;
  assign branch_code_out = r_ff.branch_code;
  assign branch_addr_out = r_ff.branch_addr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_word2_req;
    clk_en_in && r_ff.state == DSD_S_EXEC && take && word_in[15:12] == 4'hf;
  endsequence


  // One word accepted in the execute state; every check except the branch checks starts from it.
  sequence s_exec_take;
    clk_en_in && take && r_ff.state == DSD_S_EXEC;
  endsequence

  sequence s_word2_take;
    clk_en_in && r_ff.state == DSD_S_WORD2 && word_valid_in;
  endsequence

  // ---------------------------------------------------------------
  // Immediate and pointer checks
  // ---------------------------------------------------------------
  mulk_const_a: assert property (s_exec_take ##0 (word_in[15:13] == 3'b100)
      |=> ctrl_out.mult_k_en && ctrl_out.mult_k == $past(word_in[12:0]))
    else $error("multiply constant not issued");
  acc_zext_a: assert property (s_exec_take ##0 (hb == DSD_HB_ACIM)
      |=> ctrl_out.acc_op == DSD_A_LOAD_K && ctrl_out.imm8 == $past(lb))
    else $error("short accumulator load wrong");
  sel_imm_a: assert property (s_exec_take ##0 (word_in[15:1] == 15'h3440)
      |=> asel_out == $past(word_in[0]))
    else $error("pointer immediate not loaded");
  page_imm_a: assert property (s_exec_take ##0 (word_in[15:1] == 15'h3700)
      |=> pg_out == $past(word_in[0]))
    else $error("page bit not loaded");
  imm_one_a: assert property (s_exec_take ##0 (word_in[15:13] == 3'b100 || hb == DSD_HB_ACIM)
      |=> word_ready_out && ctrl_out.valid)
    else $error("immediate op not single cycle");
  aux_imm_a: assert property (s_exec_take ##0 (word_in[15:9] == 7'b0111000)
      |=> ($past(word_in[8]) ? ar1_out : ar0_out) == {8'h00, $past(lb)})
    else $error("aux immediate not loaded");
  aux_mem_a: assert property (s_exec_take ##0 (word_in[15:9] == 7'b0011100)
      |=> ctrl_out.mem_rd && ar0_out == $past(r_ff.ar0) && ar1_out == $past(r_ff.ar1))
    else $error("aux memory load wrong");
  ar_dec_a: assert property (s_exec_take ##0 (word_in == 16'h0898 && !r_ff.asel)
      |=> ar0_out == $past(r_ff.ar0) - 16'h0001)
    else $error("post decrement missing");
  ar_inc_a: assert property (s_exec_take ##0 (word_in[15:12] == 4'h0 && word_in[7])
      ##0 (word_in[5] && !r_ff.asel) |=> ar0_out == $past(r_ff.ar0) + 16'h0001)
    else $error("post increment missing");
  narp_a: assert property (s_exec_take ##0 (word_in[15:12] == 4'h0 && word_in[7])
      ##0 !word_in[3] |=> asel_out == $past(word_in[0]))
    else $error("new pointer not taken");
  dma_form_a: assert property (s_exec_take ##0 (word_in[15:12] == 4'h0 && !word_in[7])
      |=> ctrl_out.dma == {$past(pg_out), $past(word_in[6:0])})
    else $error("direct address wrong");

  // ---------------------------------------------------------------
  // Opcode group checks
  // ---------------------------------------------------------------
  add_shift_a: assert property (s_exec_take ##0 (word_in[15:12] == 4'h0)
      |=> ctrl_out.acc_op == DSD_A_ADD_SH && ctrl_out.shift == $past(word_in[11:8]))
    else $error("add with shift wrong");
  store_hi_a: assert property (s_exec_take ##0 (word_in[15:11] == 5'b01011)
      |=> ctrl_out.mem_wr_acc_hi && ctrl_out.store_shift == $past(word_in[10:8]))
    else $error("upper store shift wrong");
  load_upper_a: assert property (s_exec_take ##0 (hb == DSD_HB_ZLDH)
      |=> ctrl_out.acc_op == DSD_A_ZLDH && ctrl_out.mem_rd)
    else $error("upper load wrong");
  add_unsigned_a: assert property (s_exec_take ##0 (hb == DSD_HB_ADDU)
      |=> ctrl_out.acc_op == DSD_A_ADD_US && ctrl_out.mem_rd)
    else $error("unsigned add wrong");
  temp_acc_a: assert property (s_exec_take ##0 (hb == DSD_HB_LTAC)
      |=> ctrl_out.load_t && ctrl_out.acc_op == DSD_A_ADD_P && !ctrl_out.copy_next)
    else $error("temp accumulate wrong");
  temp_move_a: assert property (s_exec_take ##0 (hb == DSD_HB_LTD)
      |=> ctrl_out.load_t && ctrl_out.acc_op == DSD_A_ADD_P && ctrl_out.copy_next)
    else $error("temp move wrong");
  mult_mem_a: assert property (s_exec_take ##0 (hb == DSD_HB_MULM)
      |=> ctrl_out.mult_mem_en && ctrl_out.mem_rd)
    else $error("memory multiply wrong");
  status_move_a: assert property (s_exec_take ##0 (hb == DSD_HB_STLD || hb == DSD_HB_STST)
      |=> (ctrl_out.status_ld ^ ctrl_out.status_st) && ctrl_out.status_ld == $past(hb[0]))
    else $error("status move wrong");
  data_copy_a: assert property (s_exec_take ##0 (hb == DSD_HB_COPY)
      |=> ctrl_out.copy_next && ctrl_out.mem_rd && ctrl_out.acc_op == DSD_A_NONE)
    else $error("data copy wrong");
  acc_misc_a: assert property (s_exec_take ##0 (hb == DSD_HB_MISC && lb[7:1] == 7'h44)
      |=> ctrl_out.acc_op == ($past(lb[0]) ? DSD_A_ZERO : DSD_A_MAG) && word_ready_out)
    else $error("accumulator op wrong");

  // ---------------------------------------------------------------
  // Branch and wait checks
  // ---------------------------------------------------------------
  word2_fetch_a: assert property (s_word2_req |=> fetch_word2_out && !ctrl_out.valid)
    else $error("second word not requested");
  word2_hold_a: assert property (clk_en_in && r_ff.state == DSD_S_WORD2
      && !word_valid_in |=> fetch_word2_out && !branch_out)
    else $error("second word request dropped");
  branch_issue_a: assert property (s_word2_take ##0 (r_ff.br_code != DSD_BR_TESTPIN)
      |=> branch_out && ctrl_out.valid && branch_addr_out == $past(word_in[11:0]))
    else $error("branch not issued");
  testpin_nop_a: assert property (s_word2_take ##0 (r_ff.br_code == DSD_BR_TESTPIN)
      |=> !branch_out && ctrl_out.valid && ctrl_out.acc_op == DSD_A_NONE)
    else $error("test pin branch not a nop");
  port_wait_a: assert property (s_exec_take ##0 (word_in[15:12] == 4'h4)
      |=> !word_ready_out && ctrl_out.port_addr == $past(word_in[10:8]))
    else $error("port op not held");
  stack_wait_a: assert property (s_exec_take ##0 (hb == DSD_HB_MISC && lb[7:1] == 7'h4e)
      ##1 clk_en_in |=> word_ready_out)
    else $error("stack op not two cycles");
  table_wait_a: assert property (s_exec_take ##0 (hb == DSD_HB_TBW)
      ##1 clk_en_in[*2] |=> r_ff.state == DSD_S_EXEC)
    else $error("table write not three cycles");
endmodule

/* dsd_pmem_model.sv */
// Program memory model that hands instruction words to the decoder.
`timescale 1ns/10ps
module dsd_pmem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ready_in,
  input wire logic clk_en_in,
  input wire logic stall_in,
  output logic valid_out,
  output logic [15:0] word_out
);
  logic [15:0] q[$];
  logic [15:0] last;
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask
  // A word stays on the lines until taken; idle lines show the inverted last word.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      word_out <= 16'h0;
      last = 16'h0;
    end else if (!(valid_out && !(ready_in && clk_en_in))) begin
      if (valid_out) last = q.pop_front();
      if (q.size() > 0 && !stall_in) begin
        valid_out <= 1'b1;
        word_out <= q[0];
      end else begin
        valid_out <= 1'b0;
        word_out <= ~last;
      end
    end
  end
endmodule

/* tb.sv */
// Self-checking bench: decoder fed by the program memory model.
`timescale 1ns/10ps
module tb;
  import dsd_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic stall = 1'b0;
  logic wvalid, wready, asel, pg, fw2, br, bs, fs;
  logic [15:0] word, ar0, ar1;
  logic [3:0] bcode;
  logic [11:0] baddr;
  dsd_ctrl_t ctrl, cs;
  logic [15:0] lfsr = 16'h002a;
  logic e_asel = 1'b0;
  logic e_pg = 1'b0;
  logic [15:0] e_ar[2] = '{16'h0, 16'h0};
  int fails = 0;
  int check_count = 0;

  dsd_pmem_model pm (.clk_in(mclk_in), .rst_in(rst_in), .ready_in(wready),
    .clk_en_in(clk_en_in), .stall_in(stall), .valid_out(wvalid), .word_out(word));
  dsd_decoder #(.WORD_W(DSD_W)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .word_valid_in(wvalid), .word_in(word), .word_ready_out(wready),
    .ctrl_out(ctrl), .asel_out(asel), .pg_out(pg), .ar0_out(ar0), .ar1_out(ar1),
    .fetch_word2_out(fw2), .branch_out(br), .branch_code_out(bcode),
    .branch_addr_out(baddr));

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Random stalls make the memory answer promptly or slowly.
  always @(posedge mclk_in) begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    stall <= lfsr[2] & lfsr[9];
  end

  function automatic int cycles_of(input logic [15:0] w);
    if (w == 16'hf600) return 0;
    if (w[15:8] == DSD_HB_MISC && w[7:1] == 7'h4e) return 2;
    if (w[15:12] == 4'h4) return 2;
    if (w[15:8] == DSD_HB_LTBR || w[15:8] == DSD_HB_TBW) return 3;
    return 1;
  endfunction
  function automatic dsd_acc_op_t acc_of(input logic [15:0] w);
    case (w[15:8])
      DSD_HB_ADDU: return DSD_A_ADD_US;
      DSD_HB_ZLDH: return DSD_A_ZLDH;
      DSD_HB_LTAC, DSD_HB_LTD: return DSD_A_ADD_P;
      DSD_HB_MISC: begin
        if (w[7:0] == DSD_LB_MAG) return DSD_A_MAG;
        if (w[7:0] == DSD_LB_CLR) return DSD_A_ZERO;
        return w[7:0] == DSD_LB_POP ? DSD_A_POP : DSD_A_NONE;
      end
      default: return w[15:12] == 4'h0 ? DSD_A_ADD_SH : DSD_A_NONE;
    endcase
  endfunction
  function automatic logic [12:0] flags_of(input logic [15:0] w);
    logic [7:0] h;
    h = w[15:8];
    return {w[15:12] == 4'h0 || w[15:9] == 7'h1c || (h inside {DSD_HB_ADDU, DSD_HB_ZLDH,
      DSD_HB_COPY, DSD_HB_LT, DSD_HB_LTD, DSD_HB_LTAC, DSD_HB_MULM, DSD_HB_STLD}),
      h == DSD_HB_LTD || h == DSD_HB_LTAC, h == DSD_HB_LTD || h == DSD_HB_COPY,
      h == DSD_HB_MULM, h == DSD_HB_STLD, h == DSD_HB_STST, w[15:11] == 5'h0b,
      w[15:11] == 5'h08, w[15:11] == 5'h09, h == DSD_HB_LTBR, h == DSD_HB_TBW,
      w == {DSD_HB_MISC, DSD_LB_PUSH}, w == {DSD_HB_MISC, DSD_LB_POP}};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Samples at the falling edge after the edge that took the word; returns once the decoder is ready again.
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    pm.put(w);
    do begin
      @(posedge mclk_in);
      n++;
    end while (!(wvalid === 1'b1 && wready === 1'b1 && word === w) && n < 60);
    @(negedge mclk_in);
    cs = ctrl;
    bs = br;
    fs = fw2;
    chk("taken", 1, n < 60);
    if (w[15:12] != 4'hf) chk("valid", 1, cs.valid);
    n = 0;
    while (wready !== 1'b1 && n < 9) begin
      @(negedge mclk_in);
      n++;
    end
    if (cycles_of(w) != 0) chk("busy", cycles_of(w) - 1, n);
  endtask
  task automatic ptrs();
    chk("aux select", e_asel, asel);
    chk("page bit", e_pg, pg);
    chk("ar0", e_ar[0], ar0);
    chk("ar1", e_ar[1], ar1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  initial begin
    logic [15:0] w;
    int n;
    logic [15:0] ind[6] = '{16'h0898, 16'h08a8, 16'h0888, 16'h08a1, 16'h0898, 16'h08a0};
    logic [3:0] codes[11] = '{4'h9, 4'h4, 4'hd, 4'hc, 4'hb, 4'ha, 4'he, 4'h5, 4'hf, 4'h8, 4'h6};
    logic [15:0] ops[19] = '{16'h6100, 16'h6500, 16'h6b00, 16'h6c88, 16'h6d00, 16'h7b00,
      16'h7c00, 16'h6900, 16'h5d00, 16'h0300, 16'h7f88, 16'h7f89, 16'h7f9c, 16'h7f9d,
      16'h4300, 16'h4e00, 16'h6700, 16'h7d00, 16'h3800};
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    ptrs();
    for (int i = 0; i < 4; i++) begin
      exec({DSD_HB_PGIM, 7'h0, i[0]});
      e_pg = i[0];
      exec({DSD_HB_MAR, 7'h40, ~i[0]});
      e_asel = ~i[0];
      w = {7'h38, i[1], lfsr[7:0]};
      exec(w);
      e_ar[i[1]] = {8'h0, w[7:0]};
      ptrs();
    end
    $display("test pointer loads done");
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'h7eff : {DSD_HB_ACIM, lfsr[7:0]};
      exec(w);
      chk("load_acc_short_imm", {DSD_A_LOAD_K, w[7:0]}, {cs.acc_op, cs.imm8});
      w = (i == 0) ? 16'h9fff : {3'h4, lfsr[12:0]};
      exec(w);
      chk("multiply_immediate", {1'b1, w[12:0]}, {cs.mult_k_en, cs.mult_k});
    end
    $display("test immediates done");
    exec(16'h7000);
    exec(16'h6880);
    e_ar[0] = 16'h0;
    e_asel = 1'b0;
    for (int b = 0; b < 2; b++) begin
      foreach (ind[i]) begin
        if (b == 0) exec(ind[i]);
        else pm.put(ind[i]);
        if (ind[i][5]) e_ar[e_asel]++;
        if (ind[i][4]) e_ar[e_asel]--;
        if (!ind[i][3]) e_asel = ind[i][0];
        if (b == 0) ptrs();
      end
    end
    n = 0;
    while (pm.q.size() > 0 && n < 80) begin
      @(negedge mclk_in);
      n++;
    end
    @(negedge mclk_in);
    ptrs();
    $display("test indirect modify done");
    for (int r = 0; r < 3; r++) begin
      exec({DSD_HB_PGIM, 7'h0, ~r[0]});
      e_pg = ~r[0];
      foreach (ops[i]) begin
        w = ops[i];
        if (w[7:0] == 8'h0) w[6:0] = lfsr[6:0];
        if (w[15:12] == 4'h0) w[11:8] = lfsr[11:8];
        else if (w[15:11] == 5'h0b || w[15:12] == 4'h4) w[10:8] = lfsr[10:8];
        exec(w);
        chk("acc op", acc_of(w), cs.acc_op);
        chk("flags", flags_of(w), {cs.mem_rd, cs.load_t, cs.copy_next, cs.mult_mem_en, cs.status_ld,
          cs.status_st, cs.mem_wr_acc_hi, cs.port_in, cs.port_out, cs.table_rd,
          cs.table_wr, cs.push, cs.pop});
        if (!w[7]) chk("dma", {e_pg, w[6:0]}, cs.dma);
        if (w[15:12] == 4'h0) chk("shift", w[11:8], cs.shift);
        if (w[15:11] == 5'h0b) chk("store shift", w[10:8], cs.store_shift);
        if (w[15:12] == 4'h4) chk("port", w[10:8], cs.port_addr);
      end
    end
    $display("test opcode map done");
    foreach (codes[i]) begin
      w = {4'h0, lfsr[11:0]};
      if (codes[i] == DSD_BR_TESTPIN) w[7] = 1'b0;
      exec({4'hf, codes[i], 8'h0});
      if (codes[i] != DSD_BR_TESTPIN) chk("second fetch", 1, fs);
      exec(w);
      if (codes[i] == DSD_BR_TESTPIN) chk("no branch", 0, bs);
      else chk("target", {1'b1, codes[i], w[11:0]}, {bs, bcode, baddr});
    end
    $display("test branches done");
    print_verdict();
  end
endmodule
